// *** common/pld_consts.vh ***
// constants and register map of the programmable logic block
// Behaviour
// - idle non-turbo arrays enter standby after 70 ns
// - power reg 0 bit 3 is turbo control
// - power reg 2 bits block five control inputs
// - both arrays share one 82-signal input bus
// - alternate mode takes address inputs from A19-A4
// - eight primary sector selects, three terms each
// - four secondary sector selects, three terms each
// - one sram select of three terms
// - config, programming-port and two peripheral selects
// - eight chip selects using no output macrocell
// - general AND plane holds 196 product terms
// - sixteen output and twenty-four input macrocells
// - software loads and reads back macrocells
// - group a on D0-D7, lanes swappable
// - group a drives port a, b port b
// - xor polarity on summed product terms
// - mux picks registered or combinational, fed back
// - flip-flop works as D, T, JK or SR
// - clock from product term or external pin
// - active-high preset, clear of two terms
// - native and borrowed product terms per macrocell
// - host load on strobe end overrides clear, preset and clock
// - per-group mask blocks host loads, resets zero
`ifndef PLD_CONSTS_VH
`define PLD_CONSTS_VH
// timing
`define PLD_CLK_NS      5
`define PLD_IDLE_NS     70
`define PLD_IDLE_CYC    ((`PLD_IDLE_NS + `PLD_CLK_NS - 1) / `PLD_CLK_NS)
// input bus and product terms
`define PLD_BUS_W       82
`define PLD_B_EXTCLK    46
`define PLD_TERM_W      176
`define PLD_EN_BIT      164
`define PLD_TERM_WORDS  11
`define PLD_GEN_TERMS   196
`define PLD_ALL_TERMS   239
`define PLD_USED_TERMS  171
`define PLD_DEC_PT      3
`define PLD_T_PRI       0
`define PLD_T_SEC       24
`define PLD_T_SRAM      36
`define PLD_T_CFG       39
`define PLD_T_PROG      40
`define PLD_T_PERI      41
`define PLD_T_NAT       43
`define PLD_T_CLK       99
`define PLD_T_PRE       115
`define PLD_T_CLR       131
`define PLD_T_ECS       163
// macrocells
`define PLD_GRP         8
`define PLD_CELLS       16
`define PLD_NAT_A       3
`define PLD_NAT_B       4
`define PLD_BOR_A       6
`define PLD_BOR_BL      5
`define PLD_BOR_BH      6
`define PLD_BOR_SPLIT   4
`define PLD_BOR_MAX     6
// register addresses
`define PLD_A_PMR0      13'h0000
`define PLD_A_PMR2      13'h0001
`define PLD_A_CTRL      13'h0002
`define PLD_A_OMC       13'h0003
`define PLD_A_IMCAB     13'h0004
`define PLD_A_IMCC      13'h0005
`define PLD_A_MASKA     13'h0006
`define PLD_A_MASKB     13'h0007
`define PLD_A_STAT      13'h0008
`define PLD_A_ECSPOL    13'h0009
`define PLD_A_CELL_HI   9'h001
// fields
`define PLD_TURBO_BIT   3
`define PLD_CTRL_ALT    0
`define PLD_CTRL_SWAP   1
`define PLD_C_POL       0
`define PLD_C_REG       1
`define PLD_C_TYPE      2
`define PLD_C_XCLK      4
`define PLD_C_BOR       5
`define PLD_C_CLR2      11
`define PLD_FF_D        2'h0
`define PLD_FF_T        2'h1
`define PLD_FF_JK       2'h2
`define PLD_FF_SR       2'h3
// reset values
`define PLD_PMR0_RST    8'h08
`define PLD_PMR2_RST    5'h00
`define PLD_CTRL_RST    2'h0
`define PLD_MASK_RST    8'h00
`define PLD_ECSPOL_RST  8'h00
`define PLD_CELL_RST    16'h0000
`endif

// *** hdl/pld_logic.v ***
// decode array and general logic array with input and output macrocells
`include "pld_consts.vh"

module pld_logic
(
  input  wire        clk,          // 200 MHz clock
  input  wire        rst,          // synchronous reset, active high
  input  wire [12:0] regAddr,      // register address
  input  wire [15:0] regWdata,     // register write data
  input  wire        regWr,        // register write strobe
  input  wire        regRd,        // register read strobe
  output wire [15:0] regRdata,     // read data, cycle after regRd
  input  wire [19:0] hostAddr,     // host address pins
  input  wire [2:0]  hostCtrl,     // host control lines
  input  wire        pdnIn,        // power-down input
  input  wire [7:0]  portAIn,      // port a pins
  input  wire [7:0]  portBIn,      // port b pins
  input  wire [7:0]  portCIn,      // port c pins
  input  wire [3:0]  portDIn,      // port d pins, bit 1 is macrocell clock
  input  wire [7:0]  portFIn,      // port f pins
  input  wire [7:0]  pageBits,     // page register, same clock
  input  wire        flashReady,   // flash ready/busy, same clock
  output wire [7:0]  portAOut,     // group a macrocell outputs
  output wire [7:0]  portBOut,     // group b macrocell outputs
  output wire [7:0]  primarySel,   // primary flash sector selects
  output wire [3:0]  secondarySel, // secondary flash sector selects
  output wire        sramSel,      // sram select
  output wire        cfgBlockSel,  // config block select
  output wire        progPortSel,  // programming port enable
  output wire [1:0]  periphSel,    // peripheral-mode selects
  output wire [7:0]  extChipSel,   // external chip selects
  output wire        standby       // arrays idle in standby
);

  //--------------------------------------------------------------
  // helpers
  //--------------------------------------------------------------
  function ptEval;
    input [`PLD_TERM_W-1:0] cfg;
    input [`PLD_BUS_W-1:0]  b;
    begin
      ptEval = cfg[`PLD_EN_BIT] &
        ~|((cfg[`PLD_BUS_W-1:0] & ~b) |
           (cfg[2*`PLD_BUS_W-1:`PLD_BUS_W] & b));
    end
  endfunction

  function integer natBase;
    input integer c;
    begin
      if (c < `PLD_GRP)
        natBase = `PLD_T_NAT + `PLD_NAT_A * c;
      else
        natBase = `PLD_T_NAT + `PLD_NAT_A * `PLD_GRP + `PLD_NAT_B * (c - `PLD_GRP);
    end
  endfunction

  function integer natCount;
    input integer c;
    begin
      natCount = (c < `PLD_GRP) ? `PLD_NAT_A : `PLD_NAT_B;
    end
  endfunction

  function integer borMax;
    input integer c;
    begin
      if (c < `PLD_GRP)
        borMax = `PLD_BOR_A;
      else if (c - `PLD_GRP < `PLD_BOR_SPLIT)
        borMax = `PLD_BOR_BL;
      else
        borMax = `PLD_BOR_BH;
    end
  endfunction

  // borrowable terms are the natives of the following cells of the group
  function integer borrowTerm;
    input integer c;
    input integer j;
    integer n;
    integer g;
    begin
      n = natCount(c);
      g = (c < `PLD_GRP) ? 0 : `PLD_GRP;
      borrowTerm = natBase(g + (c - g + 1 + j / n) % `PLD_GRP) + j % n;
    end
  endfunction

  function [15:0] swapLanes;
    input [15:0] d;
    input        en;
    begin
      swapLanes = en ? {d[7:0], d[15:8]} : d;
    end
  endfunction

  //--------------------------------------------------------------
  // state
  //--------------------------------------------------------------
  localparam integer IDLE_INT = `PLD_IDLE_CYC;
  localparam [3:0]   IDLE_CYC = IDLE_INT[3:0];
  reg  [59:0]             pinMeta_r;
  reg  [59:0]             pinSync_r;
  reg  [7:0]              pmr0_r;
  reg  [4:0]              pmr2_r;
  reg  [1:0]              ctrl_r;
  reg  [7:0]              maskA_r;
  reg  [7:0]              maskB_r;
  reg  [7:0]              ecsPol_r;
  reg  [15:0]             cellCfg_r [0:`PLD_CELLS-1];
  reg  [`PLD_TERM_W-1:0]  termCfg [0:`PLD_ALL_TERMS-1];
  reg  [`PLD_BUS_W-1:0]   busPrev_r;
  reg  [3:0]              idleCnt_r;
  reg                     standby_r;
  reg  [15:0]             ff_r;
  reg  [15:0]             ptClkPrev_r;
  reg                     extClkPrev_r;
  reg  [15:0]             omc_r;
  reg  [7:0]              primary_r;
  reg  [3:0]              secondary_r;
  reg                     sram_r;
  reg                     cfgBlk_r;
  reg                     prog_r;
  reg  [1:0]              periph_r;
  reg  [7:0]              ecs_r;
  reg  [15:0]             rdata_r;
  reg  [15:0]             rdNxt;
  reg  [`PLD_USED_TERMS-1:0] pt;
  reg  [15:0]             natSum;
  reg  [15:0]             borSum;
  reg  [15:0]             sumPol;
  reg  [15:0]             clkEv;
  reg  [15:0]             ffNxt;
  reg  [15:0]             omcNxt;
  reg  [7:0]              priNxt;
  reg  [3:0]              secNxt;
  reg  [7:0]              ecsNxt;
  integer                 t, c, k, m;

  //--------------------------------------------------------------
  // pin synchronisers and input bus
  //--------------------------------------------------------------
  wire [59:0] pinRaw = {portFIn, portDIn, portCIn, portBIn, portAIn,
                        pdnIn, hostCtrl, hostAddr};

  always @(posedge clk)
  begin
    pinMeta_r <= pinRaw;
    pinSync_r <= pinMeta_r;
  end
  wire [19:0] sAddr  = pinSync_r[19:0];
  wire [2:0]  sCtrl  = pinSync_r[22:20];
  wire        sPdn   = pinSync_r[23];
  wire [23:0] imcOut = pinSync_r[47:24];
  wire [3:0]  sPortD = pinSync_r[51:48];
  wire [7:0]  sPortF = pinSync_r[59:52];
  // blocked control inputs read as zero so they stop toggling the arrays
  wire [2:0]  gCtrl  = sCtrl & ~pmr2_r[2:0];
  wire [3:0]  gPortD = {sPortD[3] & ~pmr2_r[4], sPortD[2:1],
                        sPortD[0] & ~pmr2_r[3]};
  wire [15:0] addrIn = ctrl_r[`PLD_CTRL_ALT] ? sAddr[19:4] : sAddr[15:0];
  wire        turbo  = pmr0_r[`PLD_TURBO_BIT];

  // feedback taken from the output flops to keep the AND plane loop-free
  wire [`PLD_BUS_W-1:0] bus = {flashReady, omc_r, pageBits, sPortF, gPortD,
                               imcOut, sPdn, rst, gCtrl, addrIn};

  // without turbo the arrays see the bus one cycle late: slower, quieter
  wire [`PLD_BUS_W-1:0] evalBus = turbo ? bus : busPrev_r;

  //--------------------------------------------------------------
  // standby detection
  //--------------------------------------------------------------
  always @(posedge clk)
  begin
    if (rst)
    begin
      busPrev_r <= {`PLD_BUS_W{1'b0}};
      idleCnt_r <= 4'h0;
      standby_r <= 1'b0;
    end
    else
    begin
      busPrev_r <= bus;
      if (bus != busPrev_r)
        idleCnt_r <= 4'h0;
      else if (idleCnt_r != IDLE_CYC)
        idleCnt_r <= idleCnt_r + 4'h1;
      standby_r <= ~turbo & (bus == busPrev_r) & (idleCnt_r == IDLE_CYC);
    end
  end

  //--------------------------------------------------------------
  // product terms and macrocell logic
  //--------------------------------------------------------------
  wire extRise = bus[`PLD_B_EXTCLK] & ~extClkPrev_r;
  wire omcLoad = regWr & (regAddr == `PLD_A_OMC);
  wire [15:0] loadData = swapLanes(regWdata, ctrl_r[`PLD_CTRL_SWAP]);
  wire [15:0] loadEn = {~maskB_r, ~maskA_r} & {16{omcLoad}};

  always @*
  begin
    for (t = 0; t < `PLD_USED_TERMS; t = t + 1)
      pt[t] = ptEval(termCfg[t], evalBus);
    for (c = 0; c < `PLD_CELLS; c = c + 1)
    begin
      natSum[c] = 1'b0;
      borSum[c] = 1'b0;
      for (k = 0; k < `PLD_NAT_B; k = k + 1)
        if (k < natCount(c))
          natSum[c] = natSum[c] | pt[natBase(c) + k];
      for (k = 0; k < `PLD_BOR_MAX; k = k + 1)
        if (k < borMax(c) && cellCfg_r[c][`PLD_C_BOR + k])
          borSum[c] = borSum[c] | pt[borrowTerm(c, k)];
      sumPol[c] = (natSum[c] | borSum[c]) ^ cellCfg_r[c][`PLD_C_POL];
      if (cellCfg_r[c][`PLD_C_XCLK])
        clkEv[c] = extRise;
      else
        clkEv[c] = pt[`PLD_T_CLK + c] & ~ptClkPrev_r[c];
      ffNxt[c] = ff_r[c];
      if (loadEn[c])
        ffNxt[c] = loadData[c];
      else if (pt[`PLD_T_CLR + 2 * c] |
               (cellCfg_r[c][`PLD_C_CLR2] & pt[`PLD_T_CLR + 2 * c + 1]))
        ffNxt[c] = 1'b0;
      else if (pt[`PLD_T_PRE + c])
        ffNxt[c] = 1'b1;
      else if (clkEv[c])
      begin
        case (cellCfg_r[c][`PLD_C_TYPE +: 2])
          `PLD_FF_D:
            ffNxt[c] = sumPol[c];
          `PLD_FF_T:
            ffNxt[c] = ff_r[c] ^ sumPol[c];
          `PLD_FF_JK:
            // j from native sum, k from borrowed sum
            ffNxt[c] = (natSum[c] ^ cellCfg_r[c][`PLD_C_POL]) & ~ff_r[c] |
                       ~borSum[c] & ff_r[c];
          `PLD_FF_SR:
            ffNxt[c] = (natSum[c] ^ cellCfg_r[c][`PLD_C_POL]) |
                       (~borSum[c] & ff_r[c]);
          default:
            ffNxt[c] = ff_r[c];
        endcase
      end
      omcNxt[c] = cellCfg_r[c][`PLD_C_REG] ? ff_r[c] : sumPol[c];
    end
    for (k = 0; k < 8; k = k + 1)
    begin
      priNxt[k] = |pt[`PLD_T_PRI + `PLD_DEC_PT * k +: `PLD_DEC_PT];
      ecsNxt[k] = pt[`PLD_T_ECS + k] ^ ecsPol_r[k];
    end
    for (k = 0; k < 4; k = k + 1)
      secNxt[k] = |pt[`PLD_T_SEC + `PLD_DEC_PT * k +: `PLD_DEC_PT];
  end

  //--------------------------------------------------------------
  // macrocell flops and array outputs
  //--------------------------------------------------------------
  always @(posedge clk)
  begin
    if (rst)
    begin
      ff_r         <= 16'h0000;
      ptClkPrev_r  <= 16'h0000;
      extClkPrev_r <= 1'b0;
      omc_r        <= 16'h0000;
      primary_r    <= 8'h00;
      secondary_r  <= 4'h0;
      sram_r       <= 1'b0;
      cfgBlk_r     <= 1'b0;
      prog_r       <= 1'b0;
      periph_r     <= 2'h0;
      ecs_r        <= 8'h00;
    end
    else
    begin
      ff_r         <= ffNxt;
      ptClkPrev_r  <= pt[`PLD_T_CLK +: `PLD_CELLS];
      extClkPrev_r <= bus[`PLD_B_EXTCLK];
      omc_r        <= omcNxt;
      primary_r    <= priNxt;
      secondary_r  <= secNxt;
      sram_r       <= |pt[`PLD_T_SRAM +: `PLD_DEC_PT];
      cfgBlk_r     <= pt[`PLD_T_CFG];
      prog_r       <= pt[`PLD_T_PROG];
      periph_r     <= pt[`PLD_T_PERI +: 2];
      ecs_r        <= ecsNxt;
    end
  end

  //--------------------------------------------------------------
  // register writes
  //--------------------------------------------------------------
  wire [7:0] termIdx = regAddr[11:4];
  wire [3:0] termWord = regAddr[3:0];
  always @(posedge clk)
  begin
    if (rst)
    begin
      pmr0_r   <= `PLD_PMR0_RST;
      pmr2_r   <= `PLD_PMR2_RST;
      ctrl_r   <= `PLD_CTRL_RST;
      maskA_r  <= `PLD_MASK_RST;
      maskB_r  <= `PLD_MASK_RST;
      ecsPol_r <= `PLD_ECSPOL_RST;
      for (m = 0; m < `PLD_CELLS; m = m + 1)
        cellCfg_r[m] <= `PLD_CELL_RST;
      for (m = 0; m < `PLD_ALL_TERMS; m = m + 1)
        termCfg[m] <= {`PLD_TERM_W{1'b0}};
    end
    else if (regWr)
    begin
      case (regAddr)
        `PLD_A_PMR0:
          pmr0_r <= regWdata[7:0];
        `PLD_A_PMR2:
          pmr2_r <= regWdata[4:0];
        `PLD_A_CTRL:
          ctrl_r <= regWdata[1:0];
        `PLD_A_MASKA:
          maskA_r <= regWdata[7:0];
        `PLD_A_MASKB:
          maskB_r <= regWdata[7:0];
        `PLD_A_ECSPOL:
          ecsPol_r <= regWdata[7:0];
        default:
        begin
          if (regAddr[12:4] == `PLD_A_CELL_HI)
            cellCfg_r[regAddr[3:0]] <= regWdata;
          else if (regAddr[12] && termIdx < `PLD_ALL_TERMS &&
                   termWord < `PLD_TERM_WORDS)
            termCfg[termIdx][{termWord, 4'h0} +: 16] <= regWdata;
        end
      endcase
    end
  end

  //--------------------------------------------------------------
  // register reads
  //--------------------------------------------------------------
  always @*
  begin
    rdNxt = 16'h0000;
    case (regAddr)
      `PLD_A_PMR0:
        rdNxt = {8'h00, pmr0_r};
      `PLD_A_PMR2:
        rdNxt = {11'h000, pmr2_r};
      `PLD_A_CTRL:
        rdNxt = {14'h0000, ctrl_r};
      `PLD_A_OMC:
        rdNxt = swapLanes(ff_r, ctrl_r[`PLD_CTRL_SWAP]);
      `PLD_A_IMCAB:
        rdNxt = swapLanes(imcOut[15:0], ctrl_r[`PLD_CTRL_SWAP]);
      `PLD_A_IMCC:
        rdNxt = {8'h00, imcOut[23:16]};
      `PLD_A_MASKA:
        rdNxt = {8'h00, maskA_r};
      `PLD_A_MASKB:
        rdNxt = {8'h00, maskB_r};
      `PLD_A_STAT:
        rdNxt = {15'h0000, standby_r};
      `PLD_A_ECSPOL:
        rdNxt = {8'h00, ecsPol_r};
      default:
      begin
        if (regAddr[12:4] == `PLD_A_CELL_HI)
          rdNxt = cellCfg_r[regAddr[3:0]];
        else if (regAddr[12] && termIdx < `PLD_ALL_TERMS &&
                 termWord < `PLD_TERM_WORDS)
          rdNxt = termCfg[termIdx][{termWord, 4'h0} +: 16];
      end
    endcase
  end

  always @(posedge clk)
  begin
    rdata_r <= (regRd & ~rst) ? rdNxt : 16'h0000;
  end

  //--------------------------------------------------------------
  // outputs
  //--------------------------------------------------------------
  assign regRdata     = rdata_r;
  assign portAOut     = omc_r[7:0];
  assign portBOut     = omc_r[15:8];
  assign primarySel   = primary_r;
  assign secondarySel = secondary_r;
  assign sramSel      = sram_r;
  assign cfgBlockSel  = cfgBlk_r;
  assign progPortSel  = prog_r;
  assign periphSel    = periph_r;
  assign extChipSel   = ecs_r;
  assign standby      = standby_r;

endmodule // pld_logic

// *** tb/pld_logic_assertions.sv ***
// concurrent checks on the ports of the programmable logic block
`include "pld_consts.vh"

module pld_logic_checker
(
  input logic        clk,      // block clock
  input logic        rst,      // synchronous reset
  input logic [12:0] regAddr,  // register address
  input logic [15:0] regWdata, // write data
  input logic        regWr,    // write strobe
  input logic        regRd,    // read strobe
  input logic [15:0] regRdata, // read data
  input logic [19:0] hostAddr, // host address pins
  input logic [2:0]  hostCtrl, // host control lines
  input logic [7:0]  portAOut, // group a outputs
  input logic [7:0]  portBOut, // group b outputs
  input logic        sramSel,  // sram select
  input logic        standby   // standby flag
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic [7:0] pmr0Shadow_r;
  logic [7:0] maskAShadow_r;
  logic [7:0] maskBShadow_r;
  logic [7:0] idleCnt_r;

  // ----------------------------------------
  // shadow registers and host idle counter
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (rst)
    begin
      pmr0Shadow_r  <= 8'h08;
      maskAShadow_r <= 8'h00;
      maskBShadow_r <= 8'h00;
    end
    else if (regWr)
    begin
      if (regAddr == `PLD_A_PMR0) pmr0Shadow_r <= regWdata[7:0];
      if (regAddr == `PLD_A_MASKA) maskAShadow_r <= regWdata[7:0];
      if (regAddr == `PLD_A_MASKB) maskBShadow_r <= regWdata[7:0];
    end
    // only a lower bound: other pins may also wake the arrays
    if (rst || !$stable(hostAddr) || !$stable(hostCtrl))
      idleCnt_r <= 8'h00;
    else if (idleCnt_r != 8'hFF)
      idleCnt_r <= idleCnt_r + 8'h01;
  end

  a_reset_quiet: assert property ($past(rst) |->
    portAOut == 8'h00 && portBOut == 8'h00 && !sramSel && regRdata == 16'h0000)
    else $error("outputs not cleared by reset");
  a_read_idle: assert property (!$past(regRd) |-> regRdata == 16'h0000)
    else $error("read data outside the read answer cycle");
  a_maska_read: assert property ($past(regRd) && $past(regAddr) == `PLD_A_MASKA
    |-> regRdata == {8'h00, maskAShadow_r}) else $error("group a mask readback wrong");
  a_maskb_read: assert property ($past(regRd) && $past(regAddr) == `PLD_A_MASKB
    |-> regRdata == {8'h00, maskBShadow_r}) else $error("group b mask readback wrong");
  a_power_read: assert property ($past(regRd) && $past(regAddr) == `PLD_A_PMR0
    |-> regRdata == {8'h00, pmr0Shadow_r}) else $error("power register readback wrong");
  a_unmapped_read: assert property ($past(regRd) && $past(regAddr) > 13'h0009
    && $past(regAddr) < 13'h0010 |-> regRdata == 16'h0000)
    else $error("unmapped read not zero");
  a_turbo_awake: assert property (pmr0Shadow_r[3] && $past(pmr0Shadow_r[3])
    && $past(pmr0Shadow_r[3], 2) |-> !standby) else $error("standby while turbo on");
  a_standby_idle: assert property ($rose(standby) |-> idleCnt_r >= 8'h0E)
    else $error("standby entered too early");
  a_standby_wake: assert property (standby && !$stable(hostAddr) |-> ##[1:6] !standby)
    else $error("standby kept after input change");
endmodule // pld_logic_checker

bind pld_logic pld_logic_checker chk_u (.clk(clk), .rst(rst), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .hostAddr(hostAddr), .hostCtrl(hostCtrl), .portAOut(portAOut), .portBOut(portBOut),
  .sramSel(sramSel), .standby(standby));

// *** tb/pld_host_model.sv ***
// host bus model driving address and control pins of the logic arrays
module pld_host_model
(
  input  logic        clk,      // block clock
  input  logic        busGo,    // host cycle requested
  input  logic [19:0] busAddr,  // address of the cycle
  output logic [19:0] hostAddr, // address pins
  output logic [2:0]  hostCtrl  // control lines
);
  timeunit 1ns;
  timeprecision 100ps;

  initial hostAddr = 20'h00000;
  initial hostCtrl = 3'h0;

  always @(posedge clk)
  begin
    if (busGo)
    begin
      hostAddr <= busAddr;
      hostCtrl <= 3'h2;
    end
    else if (hostCtrl != 3'h0)
    begin
      // released lines must not keep the last value
      hostAddr <= ~hostAddr;
      hostCtrl <= 3'h0;
    end
  end
endmodule // pld_host_model

// *** tb/test_pld_logic.sv ***
// self-checking bench for the programmable logic block
`include "pld_consts.vh"

module test_pld_logic;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk, rst, regWr, regRd, sramSel, standby, busGo, cfgBlockSel, progPortSel;
  logic [1:0]  periphSel;
  logic [12:0] regAddr;
  logic [15:0] regWdata, regRdata, v, d, prev;
  logic [19:0] hostAddr, busAddr;
  logic [2:0]  hostCtrl;
  logic [7:0]  portAIn, portBIn, portCIn, portAOut, portBOut, primarySel, extChipSel;
  logic [3:0]  portDIn, secondarySel;
  logic [31:0] rngState;
  int          badCount, comparisons;

  pld_logic dut_u (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .hostAddr(hostAddr),
    .hostCtrl(hostCtrl), .pdnIn(1'b0), .portAIn(portAIn), .portBIn(portBIn),
    .portCIn(portCIn), .portDIn(portDIn), .portFIn(8'h00), .pageBits(8'h00),
    .flashReady(1'b0), .portAOut(portAOut), .portBOut(portBOut), .primarySel(primarySel),
    .secondarySel(secondarySel), .sramSel(sramSel), .cfgBlockSel(cfgBlockSel),
    .progPortSel(progPortSel), .periphSel(periphSel), .extChipSel(extChipSel),
    .standby(standby));
  pld_host_model host_u (.clk(clk), .busGo(busGo), .busAddr(busAddr),
    .hostAddr(hostAddr), .hostCtrl(hostCtrl));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] nextRand();
    rngState = rngState ^ (rngState << 13);
    rngState = rngState ^ (rngState >> 17);
    rngState = rngState ^ (rngState << 5);
    return rngState[15:0];
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      badCount++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [12:0] a, input logic [15:0] dat);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= dat;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [12:0] a, output logic [15:0] dat);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    dat = regRdata;
  endtask

  task automatic host(input logic [19:0] a, input logic e);
    @(posedge clk);
    busGo <= 1'b1;
    busAddr <= a;
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk({15'h0000, sramSel}, {15'h0000, e});
    chk({8'h00, primarySel}, {15'h0000, e});
    chk({12'h000, secondarySel}, {15'h0000, ~e});
    @(posedge clk);
    busGo <= 1'b0;
  endtask

  task automatic pulseClk(input logic e);
    @(posedge clk);
    portDIn <= 4'h2;
    repeat (4) @(posedge clk);
    portDIn <= 4'h0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk({15'h0000, portAOut[0]}, {15'h0000, e});
  endtask

  task automatic closeOut();
    $display("checks %0d, mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // clock, watchdog, main sequence
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    badCount++;
    closeOut();
  end

  initial
  begin
    rst = 1'b1; regWr = 1'b0; regRd = 1'b0; regAddr = 13'h0000; regWdata = 16'h0000;
    portAIn = 8'h00; portBIn = 8'h00; portCIn = 8'h00; portDIn = 4'h0;
    busGo = 1'b0; busAddr = 20'h00000; rngState = 32'h0000005C;
    badCount = 0; comparisons = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(`PLD_A_PMR0, v); chk(v, 16'h0008);
    rd(`PLD_A_MASKA, v); chk(v, 16'h0000);
    rd(`PLD_A_MASKB, v); chk(v, 16'h0000);
    rd(13'h000F, v); chk(v, 16'h0000);
    d = nextRand();
    @(posedge clk);
    {portBIn, portAIn} <= d;
    portCIn <= d[11:4];
    repeat (4) @(posedge clk);
    rd(`PLD_A_IMCAB, v); chk(v, d);
    rd(`PLD_A_IMCC, v); chk(v, {8'h00, d[11:4]});
    for (int i = 0; i < 16; i++) wr(13'h0010 + i[12:0], 16'h0002);
    repeat (4)
    begin
      d = nextRand();
      wr(`PLD_A_OMC, d);
      rd(`PLD_A_OMC, v); chk(v, d);
      chk({portBOut, portAOut}, d);
    end
    prev = d;
    wr(`PLD_A_MASKA, 16'h000F);
    wr(`PLD_A_MASKB, 16'h0080);
    d = nextRand();
    wr(`PLD_A_OMC, d);
    rd(`PLD_A_OMC, v); chk(v, {prev[15], d[14:4], prev[3:0]});
    wr(`PLD_A_MASKA, 16'h0000);
    wr(`PLD_A_MASKB, 16'h0000);
    wr(`PLD_A_CTRL, 16'h0002);
    d = nextRand();
    wr(`PLD_A_OMC, d);
    rd(`PLD_A_OMC, v); chk(v, d);
    chk({portAOut, portBOut}, d);
    wr(`PLD_A_CTRL, 16'h0000);
    // inverted empty sum gives a constant one at the D, T, J or S input of cell 0
    for (int t = 0; t < 4; t++)
    begin
      wr(13'h0010, 16'h0013 | (t[15:0] << 2));
      wr(`PLD_A_OMC, 16'h0000);
      pulseClk(1'b1);
      pulseClk(t != 1);
    end
    wr(13'h1240, 16'h8000);
    wr(13'h124A, 16'h0010);
    // primary select 0 wants address bit 15 high, secondary select 0 wants it low
    wr(13'h1000, 16'h8000);
    wr(13'h100A, 16'h0010);
    wr(13'h1186, 16'h0002);
    wr(13'h118A, 16'h0010);
    // chip selects follow the polarity register while their terms are off
    wr(`PLD_A_ECSPOL, 16'h00A5);
    wr(13'h127A, 16'h0010);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({8'h00, extChipSel}, 16'h00A5);
    chk({12'h000, cfgBlockSel, progPortSel, periphSel}, 16'h0008);
    host(20'h08000, 1'b1);
    host(20'h00000, 1'b0);
    wr(`PLD_A_CTRL, 16'h0001);
    host(20'h80000, 1'b1);
    host(20'h08000, 1'b0);
    wr(`PLD_A_CTRL, 16'h0000);
    wr(`PLD_A_PMR0, 16'h0000);
    repeat (24) @(posedge clk);
    @(negedge clk);
    chk({15'h0000, standby}, 16'h0001);
    rd(`PLD_A_STAT, v); chk(v, 16'h0001);
    host(20'h00010, 1'b0);
    @(negedge clk);
    chk({15'h0000, standby}, 16'h0000);
    wr(`PLD_A_PMR0, 16'h0008);
    closeOut();
  end
endmodule // test_pld_logic
